/* inc/fifo_flags_map.vh */
// register offsets, field positions and reset values of the status flag block
`ifndef FIFO_FLAGS_MAP_VH
`define FIFO_FLAGS_MAP_VH

`define ADDR_EMPTY_OFFSET   3'h0
`define ADDR_FULL_OFFSET    3'h1
`define ADDR_WORD_COUNT     3'h2
`define ADDR_MODE_STATUS    3'h3

`define MODE_FALL_THRU_BIT  0
`define MODE_LOAD_SEL_BIT   1
`define MODE_SERIAL_BIT     2

`define OFFSET_DEFAULT_LOW  14'h007F
`define OFFSET_DEFAULT_HIGH 14'h03FF

`endif

/* src/word_store.v */
// storage array with write and read pointers and a word count
`timescale 1ns/1ps
`default_nettype none

module word_store #(
	parameter DEPTH = 8192,
	parameter AW    = 13,
	parameter CW    = 14,
	parameter DW    = 18
) (
	input  wire          clk_sys_in,
	input  wire          srst_in,
	input  wire          push_in,
	input  wire [DW-1:0] push_data_in,
	input  wire          pop_in,
	output wire [DW-1:0] head_word_out,
	output reg  [CW-1:0] stored_count_out
);

	reg [DW-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;

	// pointers wrap naturally, so DEPTH must be a power of two
	assign head_word_out = mem[rd_ptr];

	always @(posedge clk_sys_in)
	begin
		if (push_in)
			mem[wr_ptr] <= push_data_in;
	end

	always @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			stored_count_out <= {CW{1'b0}};
		end
		else
		begin
			if (push_in)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop_in)
				rd_ptr <= rd_ptr + 1'b1;
			if (push_in && !pop_in)
				stored_count_out <= stored_count_out + 1'b1;
			else if (pop_in && !push_in)
				stored_count_out <= stored_count_out - 1'b1;
		end
	end

endmodule

`default_nettype wire

/* src/level_flags.v */
// combinational threshold comparisons on a word count, active low results
`timescale 1ns/1ps
`default_nettype none

module level_flags #(
	parameter DEPTH = 8192,
	parameter CW    = 14
) (
	input  wire [CW-1:0] count_in,
	input  wire [CW-1:0] full_offset_in,
	input  wire [CW-1:0] empty_offset_in,
	output wire          almost_full_n_out,
	output wire          almost_empty_n_out,
	output wire          half_full_n_out
);

	localparam [CW:0] CAP  = DEPTH[CW:0];
	localparam [CW:0] HALF = CAP >> 1;

	wire [CW:0] count_x = {1'b0, count_in};
	wire [CW:0] full_x  = {1'b0, full_offset_in};

	// low above capacity minus offset
	// the extra bit keeps an offset above capacity from wrapping
	assign almost_full_n_out = !((count_x + full_x) > CAP);
	assign almost_empty_n_out = !(count_in < empty_offset_in);
	assign half_full_n_out = !(count_x > HALF);

endmodule

`default_nettype wire

/* src/fifo_status_flag_outputs.v */
// status flags, read data path and offset registers of a deep fifo
// Function
// - standard mode: shared output is full flag
// - fall-through mode: shared output shows free space
// - standard mode: shared output is empty flag
// - fall-through mode: shows valid word presented
// - almost-full low above capacity minus offset
// - full offset defaults to 127 or 1023
// - almost-empty low below empty offset
// - empty offset defaults to 127 or 1023
// - empty offset is user programmable
// - half-full shows count above half capacity
// - read data bus is 18 bits
// - load select at reset picks defaults and the reported method bit
`timescale 1ns/1ps
`default_nettype none
`include "fifo_flags_map.vh"

module fifo_status_flag_outputs #(
	parameter DEPTH = 8192,
	parameter AW    = 13,
	parameter CW    = 14,
	parameter DW    = 18
) (
	input  wire          clk_sys_in,
	input  wire          srst_in,
	input  wire          first_word_fall_through_in,
	input  wire          offset_load_select_in,
	input  wire          wr_en_in,
	input  wire [DW-1:0] wr_data_in,
	input  wire          rd_en_in,
	input  wire [2:0]    reg_addr_in,
	input  wire [15:0]   reg_wdata_in,
	input  wire          reg_wr_in,
	input  wire          reg_rd_in,
	output reg  [15:0]   reg_rdata_out,
	output reg  [DW-1:0] read_data_bus_out,
	output reg           full_input_ready_n_out,
	output reg           empty_output_ready_n_out,
	output reg           almost_full_level_n_out,
	output reg           almost_empty_level_n_out,
	output reg           half_full_level_n_out
);

	localparam [CW-1:0] CAP = DEPTH[CW-1:0];

	reg          fall_through_mode;
	reg          load_select;
	reg [CW-1:0] empty_offset;
	reg [CW-1:0] full_offset;
	reg          out_valid;
	reg [CW-1:0] total_count;

	wire [DW-1:0] head_word;
	wire [CW-1:0] mem_count;
	wire          mem_has_word = (mem_count != {CW{1'b0}});

	reg          push;
	reg          pop;
	reg          take;
	reg          next_valid;
	reg [CW-1:0] next_total;

	wire af_n;
	wire ae_n;
	wire half_n;

	// shared by the write gate and the full or ready flag
	function at_capacity;
		input [CW-1:0] count;
		begin
			at_capacity = (count == CAP);
		end
	endfunction

	// offsets and counts sit in the low bits of a register word
	function [15:0] reg_field;
		input [CW-1:0] value;
		begin
			reg_field = {{(16-CW){1'b0}}, value};
		end
	endfunction

	// writes are refused once the total held reaches capacity
	always @*
	begin
		push = wr_en_in && !at_capacity(total_count);
		if (fall_through_mode)
		begin
			take = rd_en_in && out_valid;
			// refill the output word whenever it is free or being taken
			pop = mem_has_word && (!out_valid || rd_en_in);
			next_valid = pop || (out_valid && !rd_en_in);
		end
		else
		begin
			take = rd_en_in && mem_has_word;
			pop = take;
			next_valid = 1'b0;
		end
		// count tracks accepted writes and reads
		next_total = total_count;
		if (push && !take)
			next_total = total_count + 1'b1;
		else if (take && !push)
			next_total = total_count - 1'b1;
	end

	word_store #(
		.DEPTH (DEPTH),
		.AW    (AW),
		.CW    (CW),
		.DW    (DW)
	) u_store (
		.clk_sys_in       (clk_sys_in),
		.srst_in          (srst_in),
		.push_in          (push),
		.push_data_in     (wr_data_in),
		.pop_in           (pop),
		.head_word_out    (head_word),
		.stored_count_out (mem_count)
	);

	// flags use the next count so they land with the count itself
	level_flags #(
		.DEPTH (DEPTH),
		.CW    (CW)
	) u_levels (
		.count_in           (next_total),
		.full_offset_in     (full_offset),
		.empty_offset_in    (empty_offset),
		.almost_full_n_out  (af_n),
		.almost_empty_n_out (ae_n),
		.half_full_n_out    (half_n)
	);

	// mode and defaults are caught while reset is held
	always @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			fall_through_mode <= first_word_fall_through_in;
			load_select <= offset_load_select_in;
			// load select picks the default pair
			if (offset_load_select_in)
			begin
				full_offset <= `OFFSET_DEFAULT_HIGH;
				empty_offset <= `OFFSET_DEFAULT_HIGH;
			end
			else
			begin
				full_offset <= `OFFSET_DEFAULT_LOW;
				empty_offset <= `OFFSET_DEFAULT_LOW;
			end
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == `ADDR_EMPTY_OFFSET)
				empty_offset <= reg_wdata_in[CW-1:0];
			if (reg_addr_in == `ADDR_FULL_OFFSET)
				full_offset <= reg_wdata_in[CW-1:0];
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (srst_in)
			reg_rdata_out <= 16'h0000;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
			`ADDR_EMPTY_OFFSET:
				reg_rdata_out <= reg_field(empty_offset);
			`ADDR_FULL_OFFSET:
				reg_rdata_out <= reg_field(full_offset);
			`ADDR_WORD_COUNT:
				reg_rdata_out <= reg_field(total_count);
			`ADDR_MODE_STATUS:
			begin
				reg_rdata_out <= 16'h0000;
				reg_rdata_out[`MODE_FALL_THRU_BIT] <= fall_through_mode;
				reg_rdata_out[`MODE_LOAD_SEL_BIT] <= load_select;
				// serial loading is not built; the bit only reports the choice
				reg_rdata_out[`MODE_SERIAL_BIT] <= !load_select;
			end
			default:
				reg_rdata_out <= 16'h0000;
			endcase
		end
		else
			reg_rdata_out <= 16'h0000;
	end

	always @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			out_valid <= 1'b0;
			total_count <= {CW{1'b0}};
			read_data_bus_out <= {DW{1'b0}};
			full_input_ready_n_out <= 1'b0;
			empty_output_ready_n_out <= 1'b1;
			almost_full_level_n_out <= 1'b1;
			almost_empty_level_n_out <= 1'b0;
			half_full_level_n_out <= 1'b1;
		end
		else
		begin
			out_valid <= next_valid;
			total_count <= next_total;
			if (pop)
				read_data_bus_out <= head_word;
			if (fall_through_mode)
			begin
				full_input_ready_n_out <= at_capacity(next_total);
				// low while a word is presented
				empty_output_ready_n_out <= !next_valid;
			end
			else
			begin
				full_input_ready_n_out <= !at_capacity(next_total);
				empty_output_ready_n_out <= (next_total != {CW{1'b0}});
			end
			almost_full_level_n_out <= af_n;
			almost_empty_level_n_out <= ae_n;
			half_full_level_n_out <= half_n;
		end
	end

endmodule

`default_nettype wire

/* verif/fifo_flags_props.sv */
// assertions on the flag and register outputs of the status flag block
`timescale 1ns/1ps
`default_nettype none
module fifo_flags_props (
	input wire logic        clk_sys_in,
	input wire logic        srst_in,
	input wire logic        first_word_fall_through_in,
	input wire logic        wr_en_in,
	input wire logic        rd_en_in,
	input wire logic [2:0]  reg_addr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        full_input_ready_n_out,
	input wire logic        empty_output_ready_n_out,
	input wire logic        almost_full_level_n_out,
	input wire logic        almost_empty_level_n_out,
	input wire logic        half_full_level_n_out
);
	logic       std;
	logic [1:0] up;
	// flags still show reset values one edge after release; $fell needs one edge more
	always @(posedge clk_sys_in)
	begin
		up <= {up[0], !srst_in};
		if (srst_in)
			std <= !first_word_fall_through_in;
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
		else $error("read data outside read cycle");
	unmapped_zero_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) > 3'h3
		|-> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
	full_flags_a: assert property (std && &up && !full_input_ready_n_out
		|-> !almost_full_level_n_out && !half_full_level_n_out)
		else $error("full without level flags");
	empty_flags_a: assert property (std && &up && !empty_output_ready_n_out
		|-> !almost_empty_level_n_out && almost_full_level_n_out
		&& half_full_level_n_out) else $error("empty with wrong level flags");
	af_half_a: assert property (&up && !almost_full_level_n_out
		|-> !half_full_level_n_out) else $error("almost full but not half full");
	empty_cause_a: assert property (std && &up && $fell(empty_output_ready_n_out)
		|-> $past(rd_en_in)) else $error("empty without a read");
	full_cause_a: assert property (std && &up && $fell(full_input_ready_n_out)
		|-> $past(wr_en_in)) else $error("full without a write");
	half_cause_a: assert property (&up && $fell(half_full_level_n_out)
		|-> $past(wr_en_in)) else $error("half full without a write");
endmodule
`default_nettype wire

/* verif/fifo_far_side.sv */
// writing and reading logic facing the fifo data ports
`timescale 1ns/1ps
`default_nettype none
module fifo_far_side (
	input  wire logic        clk_sys_in,
	output var  logic        wr_en_out = 1'b0,
	output var  logic [17:0] wr_data_out = 18'h00000,
	output var  logic        rd_en_out = 1'b0
);
	logic [17:0] next_word = 18'h00000;
	// n above zero writes n words, below zero reads -n words
	task automatic move(input int n);
		int i;
		for (i = 0; i < (n < 0 ? -n : n); i++)
		begin
			@(posedge clk_sys_in);
			wr_en_out <= n > 0;
			rd_en_out <= n < 0;
			wr_data_out <= next_word;
			next_word <= next_word + 18'h00001;
		end
		@(posedge clk_sys_in);
		wr_en_out <= 1'b0;
		rd_en_out <= 1'b0;
		// idle data lines never repeat the last word
		wr_data_out <= ~wr_data_out;
		#1;
	endtask
endmodule
`default_nettype wire

/* verif/fifo_status_flag_outputs_tb.sv */
// self-checking bench for the fifo status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: %h expected %h", $time, a, b); end end
module fifo_status_flag_outputs_tb;
	logic        clk_sys_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        fall_thru = 1'b0;
	logic        load_sel = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic [17:0] d;
	wire         wr_en, rd_en;
	wire  [17:0] wr_data, q;
	wire  [15:0] rdata;
	wire  [4:0]  fl;
	int          err_total = 0;
	int          n_compared = 0;
	int steps[12] = '{126, 1, 3969, 1, 3968, 1, 126, 1, -1, -8190, -1, -1};
	logic [4:0] want[12] = '{5'h1D, 5'h1F, 5'h1F, 5'h1E, 5'h1E, 5'h1A,
		5'h0A, 5'h0A, 5'h1A, 5'h1D, 5'h15, 5'h15};
	fifo_status_flag_outputs dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.first_word_fall_through_in(fall_thru),
		.offset_load_select_in(load_sel),
		.wr_en_in(wr_en), .wr_data_in(wr_data), .rd_en_in(rd_en),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(rdata), .read_data_bus_out(q),
		.full_input_ready_n_out(fl[4]), .empty_output_ready_n_out(fl[3]),
		.almost_full_level_n_out(fl[2]), .almost_empty_level_n_out(fl[1]),
		.half_full_level_n_out(fl[0]));
	fifo_far_side p (.clk_sys_in(clk_sys_in), .wr_en_out(wr_en),
		.wr_data_out(wr_data), .rd_en_out(rd_en));
	task rst(input logic f, input logic l);
		fall_thru <= f;
		load_sel <= l;
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
	endtask
	task rr(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk_sys_in);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task rw(input logic [2:0] a, input logic [15:0] v);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
	endtask
	task complete_run;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	// the full fill and drain needs about 16400 cycles
	initial
	begin
		#1_000_000;
		err_total++;
		complete_run();
	end
	initial
	begin
		rst(1'b0, 1'b0);
		`CHK(fl, 5'h15)
		for (int k = 0; k < 12; k++)
		begin
			p.move(steps[k]);
			`CHK(fl, want[k])
		end
		rst(1'b0, 1'b1);
		rr(3'h3, 16'h0002);
		rr(3'h1, 16'h03FF);
		rr(3'h0, 16'h03FF);
		// upper bits beyond the offset width are dropped
		rw(3'h0, 16'hC005);
		rr(3'h0, 16'h0005);
		d = p.next_word;
		p.move(5);
		`CHK(fl[1], 1'b1)
		rw(3'h2, 16'h0000);
		rr(3'h2, 16'h0005);
		rr(3'h5, 16'h0000);
		p.move(-1);
		`CHK(q, d)
		`CHK(fl[1], 1'b0)
		rst(1'b1, 1'b0);
		rr(3'h1, 16'h007F);
		`CHK(fl[4:3], 2'b01)
		d = p.next_word;
		p.move(1);
		@(posedge clk_sys_in);
		#1;
		`CHK(fl[3], 1'b0)
		`CHK(q, d)
		complete_run();
	end
endmodule
bind fifo_status_flag_outputs fifo_flags_props chk (.clk_sys_in(clk_sys_in),
	.srst_in(srst_in), .first_word_fall_through_in(first_word_fall_through_in),
	.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .reg_addr_in(reg_addr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.full_input_ready_n_out(full_input_ready_n_out),
	.empty_output_ready_n_out(empty_output_ready_n_out),
	.almost_full_level_n_out(almost_full_level_n_out),
	.almost_empty_level_n_out(almost_empty_level_n_out),
	.half_full_level_n_out(half_full_level_n_out));
`default_nettype wire
